// [core/agc_pkg.sv]
// What this block does
// RULE_01: Software programs the threshold offset first; attack thresholds sit above it.
// RULE_02: Threshold offset resets to 63.9 dB above the zero-input reference.
// RULE_03: Lower attack threshold is offset plus low setting, default 12.8 dB.
// RULE_04: Upper attack threshold is offset plus upper setting, default 25.6 dB.
// RULE_05: Maximum gain returns only below lower threshold minus hysteresis, default 21.3 dB.
// RULE_06: Software may use one common setting set for every filter bandwidth.
// RULE_07: Common setting uses 63.9 dB or 51.1 dB offset by filter width.
// RULE_08: Raw strength is corrected by programmable offset and slope before thresholding.
// RULE_09: Corrected strength passes a peak filter with separate rise and fall coefficients.
// RULE_10: Each of two Schmitt triggers steers analog gain and digital gain correction.
// RULE_11: Second IF gain takes exactly one of three values from the decision.
// RULE_12: Gain state is a registered two-bit value, updated per sample, reset to maximum.
package agc_pkg;

  // Levels are carried in steps of 0.1 dB so every printed figure is exact.
  localparam int DATA_W = 16;
  localparam int ADDR_W = 6;
  localparam int RAW_W = 10;
  localparam int STR_W = 12;
  localparam int THR_W = 13;
  localparam int OFS_W = 10;
  localparam int LVL_W = 9;
  localparam int DGC_W = 8;
  localparam int SH_W = 4;
  localparam int SLOPE_W = 8;
  localparam int SLOPE_FRAC = 6;
  localparam int CORR_W = 12;
  localparam int FRAC_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_THR_OFFSET = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_LOWER = 6'h04;
  localparam logic [ADDR_W-1:0] ADDR_UPPER = 6'h08;
  localparam logic [ADDR_W-1:0] ADDR_HYST = 6'h0c;
  localparam logic [ADDR_W-1:0] ADDR_STR_OFFS = 6'h10;
  localparam logic [ADDR_W-1:0] ADDR_STR_SLOPE = 6'h14;
  localparam logic [ADDR_W-1:0] ADDR_RISE = 6'h18;
  localparam logic [ADDR_W-1:0] ADDR_FALL = 6'h1c;
  localparam logic [ADDR_W-1:0] ADDR_DGC_MID = 6'h20;
  localparam logic [ADDR_W-1:0] ADDR_DGC_LOW = 6'h24;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 6'h28;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 6'h2c;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL = 6'h30;

  localparam logic [OFS_W-1:0] RST_THR_OFFSET = 10'h27f;
  localparam logic [LVL_W-1:0] RST_LOWER = 9'h080;
  localparam logic [LVL_W-1:0] RST_UPPER = 9'h100;
  localparam logic [LVL_W-1:0] RST_HYST = 9'h0d5;
  localparam logic [CORR_W-1:0] RST_STR_OFFS = 12'h000;
  localparam logic [SLOPE_W-1:0] RST_STR_SLOPE = 8'h40;
  localparam logic [SH_W-1:0] RST_RISE = 4'h4;
  localparam logic [SH_W-1:0] RST_FALL = 4'h4;
  localparam logic [DGC_W-1:0] RST_DGC_MID = 8'h9b;
  localparam logic [DGC_W-1:0] RST_DGC_LOW = 8'hff;
  localparam logic RST_AGC_EN = 1'b1;

  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_LO_BIT = 2;
  localparam int STAT_UP_BIT = 3;

  typedef enum logic [1:0] {GAIN_MAX, GAIN_MID, GAIN_LOW} gain_step_type;

  typedef struct packed {
    logic valid;
    logic [RAW_W-1:0] level;
  } raw_sample_type;

  typedef struct packed {
    gain_step_type step;
    logic [DGC_W-1:0] digital_gain_correction;
  } gain_out_type;

endpackage

// [core/peak_memory_filter.sv]
`timescale 1ns/1ns
module peak_memory_filter #(
  parameter int W = agc_pkg::STR_W,
  parameter int F = agc_pkg::FRAC_W,
  parameter int SH = agc_pkg::SH_W
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Corrected strength and rise and fall shifts in.
  input wire logic x_valid,
  input wire logic [W-1:0] x,
  input wire logic [SH-1:0] rise_shift,
  input wire logic [SH-1:0] fall_shift,
  // Filtered strength out.
  output logic y_valid,
  output logic [W-1:0] y
);
  import agc_pkg::*;

  logic [W+F-1:0] acc_ff;
  logic y_valid_ff;
  logic signed [W+F:0] diff;
  logic signed [W+F:0] step;
  logic [W+F:0] nxt_sum;
  logic [SH:0] fall_total;

  // Decay is chained after attack, so it can never be faster than it.
  assign fall_total = {1'b0, rise_shift} + {1'b0, fall_shift};
  assign diff = $signed({1'b0, x, {F{1'b0}}}) - $signed({1'b0, acc_ff});

  always_comb begin
    step = diff[W+F] ? (diff >>> fall_total) : (diff >>> rise_shift); // see RULE_09
    nxt_sum = {1'b0, acc_ff} + step;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_ff <= '0;
    end else if (x_valid) begin
      acc_ff <= nxt_sum[W+F-1:0]; // see RULE_09
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      y_valid_ff <= 1'b0;
    end else begin
      y_valid_ff <= x_valid;
    end
  end

  assign y = acc_ff[W+F-1:F];
  assign y_valid = y_valid_ff;

  rise_bound_a: assert property (@(posedge core_clk) disable iff (srst) // see RULE_09
    x_valid && x > y |=> y >= $past(y) && y <= $past(x))
    else $error("peak filter rise left its bounds");

  fall_bound_a: assert property (@(posedge core_clk) disable iff (srst) // see RULE_09
    x_valid && x < y |=> y <= $past(y) && y >= $past(x))
    else $error("peak filter fall left its bounds");

  filter_hold_a: assert property (@(posedge core_clk) disable iff (srst) // see RULE_09
    !x_valid |=> $stable(y))
    else $error("peak filter moved without a sample");

endmodule

// [core/agc_threshold_decision.sv]
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ns
module agc_threshold_decision (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Register port.
  input wire logic [agc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [agc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [agc_pkg::DATA_W-1:0] reg_rdata,
  // Raw signal strength from the converter.
  input wire agc_pkg::raw_sample_type raw_in,
  // Gain decision to the IF stages, and the filtered level.
  output agc_pkg::gain_out_type gain_out,
  output logic [agc_pkg::STR_W-1:0] filt_level
);
  import agc_pkg::*;

  logic [OFS_W-1:0] thr_offset_ff;
  logic [LVL_W-1:0] lower_ff;
  logic [LVL_W-1:0] upper_ff;
  logic [LVL_W-1:0] hyst_ff;
  logic [CORR_W-1:0] offs_ff;
  logic [SLOPE_W-1:0] slope_ff;
  logic [SH_W-1:0] rise_ff;
  logic [SH_W-1:0] fall_ff;
  logic [DGC_W-1:0] dgc_mid_ff;
  logic [DGC_W-1:0] dgc_low_ff;
  logic agc_en_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [STR_W-1:0] corr_ff;
  logic corr_valid_ff;
  logic filt_valid;
  logic [STR_W-1:0] filt_y;
  logic [STR_W-1:0] level_ff;
  logic trig_lo_ff;
  logic trig_up_ff;
  logic nxt_trig_lo;
  logic nxt_trig_up;
  gain_step_type nxt_gain;
  gain_out_type gain_out_ff;
  logic [THR_W-1:0] lo_thr;
  logic [THR_W-1:0] up_thr;
  logic [THR_W-1:0] level_ext;
  logic [THR_W-1:0] level_hys;
  logic [DATA_W-1:0] read_mux;

  function automatic logic write_hit(input logic [ADDR_W-1:0] off);
    return reg_wr && (reg_addr == off);
  endfunction

  // The product keeps full width; only the final clamp narrows it.
  function automatic logic [STR_W-1:0] correct_level(
    input logic [RAW_W-1:0] raw,
    input logic [SLOPE_W-1:0] slope,
    input logic [CORR_W-1:0] offs
  );
    logic [RAW_W+SLOPE_W-1:0] prod;
    logic signed [RAW_W+SLOPE_W+1:0] sum;
    logic signed [RAW_W+SLOPE_W+1:0] top;
    prod = (RAW_W+SLOPE_W)'(raw) * (RAW_W+SLOPE_W)'(slope);
    sum = $signed({2'b00, prod >> SLOPE_FRAC}) + (RAW_W+SLOPE_W+2)'($signed(offs));
    top = {{(RAW_W+SLOPE_W+2-STR_W){1'b0}}, {STR_W{1'b1}}};
    if (sum < 0) begin
      return '0;
    end else if (sum > top) begin
      return '1;
    end else begin
      return sum[STR_W-1:0];
    end
  endfunction

  function automatic logic [DGC_W-1:0] dgc_of(
    input gain_step_type step,
    input logic [DGC_W-1:0] mid,
    input logic [DGC_W-1:0] low
  );
    case (step)
      GAIN_MID: return mid;
      GAIN_LOW: return low;
      default: return '0;
    endcase
  endfunction

  // Threshold registers; the offset is expected to be written first.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      thr_offset_ff <= RST_THR_OFFSET; // see RULE_02
      lower_ff <= RST_LOWER; // see RULE_03
      upper_ff <= RST_UPPER; // see RULE_04
      hyst_ff <= RST_HYST; // see RULE_05
    end else begin
      if (write_hit(ADDR_THR_OFFSET)) begin
        thr_offset_ff <= reg_wdata[OFS_W-1:0]; // see RULE_01
      end
      if (write_hit(ADDR_LOWER)) begin
        lower_ff <= reg_wdata[LVL_W-1:0];
      end
      if (write_hit(ADDR_UPPER)) begin
        upper_ff <= reg_wdata[LVL_W-1:0];
      end
      if (write_hit(ADDR_HYST)) begin
        hyst_ff <= reg_wdata[LVL_W-1:0];
      end
    end
  end

  // Strength correction and filter coefficients.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      offs_ff <= RST_STR_OFFS;
      slope_ff <= RST_STR_SLOPE;
      rise_ff <= RST_RISE;
      fall_ff <= RST_FALL;
    end else begin
      if (write_hit(ADDR_STR_OFFS)) begin
        offs_ff <= reg_wdata[CORR_W-1:0];
      end
      if (write_hit(ADDR_STR_SLOPE)) begin
        slope_ff <= reg_wdata[SLOPE_W-1:0];
      end
      if (write_hit(ADDR_RISE)) begin
        rise_ff <= reg_wdata[SH_W-1:0];
      end
      if (write_hit(ADDR_FALL)) begin
        fall_ff <= reg_wdata[SH_W-1:0];
      end
    end
  end

  // Digital gain correction values and enable.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dgc_mid_ff <= RST_DGC_MID;
      dgc_low_ff <= RST_DGC_LOW;
      agc_en_ff <= RST_AGC_EN;
    end else begin
      if (write_hit(ADDR_DGC_MID)) begin
        dgc_mid_ff <= reg_wdata[DGC_W-1:0];
      end
      if (write_hit(ADDR_DGC_LOW)) begin
        dgc_low_ff <= reg_wdata[DGC_W-1:0];
      end
      if (write_hit(ADDR_CTRL)) begin
        agc_en_ff <= reg_wdata[CTRL_EN_BIT];
      end
    end
  end

  always_comb begin
    read_mux = '0;
    case (reg_addr)
      ADDR_THR_OFFSET: read_mux = DATA_W'(thr_offset_ff);
      ADDR_LOWER: read_mux = DATA_W'(lower_ff);
      ADDR_UPPER: read_mux = DATA_W'(upper_ff);
      ADDR_HYST: read_mux = DATA_W'(hyst_ff);
      ADDR_STR_OFFS: read_mux = DATA_W'(offs_ff);
      ADDR_STR_SLOPE: read_mux = DATA_W'(slope_ff);
      ADDR_RISE: read_mux = DATA_W'(rise_ff);
      ADDR_FALL: read_mux = DATA_W'(fall_ff);
      ADDR_DGC_MID: read_mux = DATA_W'(dgc_mid_ff);
      ADDR_DGC_LOW: read_mux = DATA_W'(dgc_low_ff);
      ADDR_CTRL: read_mux = DATA_W'(agc_en_ff);
      ADDR_STATUS: read_mux = DATA_W'({trig_up_ff, trig_lo_ff, gain_out_ff.step});
      ADDR_LEVEL: read_mux = DATA_W'(level_ff);
      default: read_mux = '0;
    endcase
  end

  // Read data stand for one cycle only, zero otherwise.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= reg_rd ? read_mux : '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      corr_ff <= '0;
      corr_valid_ff <= 1'b0;
    end else begin
      corr_valid_ff <= raw_in.valid;
      if (raw_in.valid) begin
        corr_ff <= correct_level(raw_in.level, slope_ff, offs_ff); // see RULE_08
      end
    end
  end

  peak_memory_filter #(
    .W(STR_W),
    .F(FRAC_W),
    .SH(SH_W)
  ) u_peak (
    .core_clk(core_clk),
    .srst(srst),
    .x_valid(corr_valid_ff),
    .x(corr_ff),
    .rise_shift(rise_ff),
    .fall_shift(fall_ff),
    .y_valid(filt_valid),
    .y(filt_y)
  );

  always_ff @(posedge core_clk) begin
    if (srst) begin
      level_ff <= '0;
    end else if (filt_valid) begin
      level_ff <= filt_y;
    end
  end

  assign lo_thr = THR_W'(thr_offset_ff) + THR_W'(lower_ff); // see RULE_03
  assign up_thr = THR_W'(thr_offset_ff) + THR_W'(upper_ff); // see RULE_04
  assign level_ext = THR_W'(filt_y);
  // Adding hysteresis to the level avoids an underflowing threshold.
  assign level_hys = level_ext + THR_W'(hyst_ff);

  // Two Schmitt triggers; a disabled block falls back to maximum gain per sample.
  always_comb begin
    nxt_trig_lo = trig_lo_ff;
    nxt_trig_up = trig_up_ff;
    if (filt_valid) begin
      if (!agc_en_ff) begin
        nxt_trig_lo = 1'b0;
        nxt_trig_up = 1'b0;
      end else begin
        if (level_ext >= lo_thr) begin
          nxt_trig_lo = 1'b1; // see RULE_03
        end else if (level_hys < lo_thr) begin
          nxt_trig_lo = 1'b0; // see RULE_05
        end
        if (level_ext >= up_thr) begin
          nxt_trig_up = 1'b1; // see RULE_04
        end else if (level_hys < up_thr) begin
          nxt_trig_up = 1'b0;
        end
      end
    end
  end

  always_comb begin
    if (nxt_trig_up) begin
      nxt_gain = GAIN_LOW; // see RULE_11
    end else if (nxt_trig_lo) begin
      nxt_gain = GAIN_MID;
    end else begin
      nxt_gain = GAIN_MAX;
    end
  end

  // Step and correction share one process, as both are fields of one output word.
  // Correction follows register writes even while the gain step holds.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      trig_lo_ff <= 1'b0;
      trig_up_ff <= 1'b0;
      gain_out_ff.step <= GAIN_MAX; // see RULE_12
      gain_out_ff.digital_gain_correction <= '0;
    end else begin
      trig_lo_ff <= nxt_trig_lo;
      trig_up_ff <= nxt_trig_up;
      gain_out_ff.step <= nxt_gain; // see RULE_12
      gain_out_ff.digital_gain_correction <= dgc_of(nxt_gain, dgc_mid_ff, dgc_low_ff); // see RULE_10
    end
  end

  assign reg_rdata = rdata_ff;
  assign gain_out = gain_out_ff;
  assign filt_level = level_ff;

  sequence lower_cross_s;
    filt_valid && agc_en_ff && level_ext >= lo_thr;
  endsequence

  sequence upper_cross_s;
    filt_valid && agc_en_ff && level_ext >= up_thr;
  endsequence

  sequence release_s;
    filt_valid && agc_en_ff && level_hys < lo_thr && level_ext < lo_thr;
  endsequence

  reset_defaults_a: assert property (@(posedge core_clk) // see RULE_02
    srst |=> thr_offset_ff == RST_THR_OFFSET && lower_ff == RST_LOWER
      && upper_ff == RST_UPPER && hyst_ff == RST_HYST)
    else $error("threshold defaults wrong after reset");

  lower_attack_a: assert property (@(posedge core_clk) disable iff (srst) // see RULE_03
    lower_cross_s |=> trig_lo_ff && gain_out_ff.step != GAIN_MAX)
    else $error("lower threshold crossing did not cut gain");

  upper_attack_a: assert property (@(posedge core_clk) disable iff (srst) // see RULE_04
    upper_cross_s |=> gain_out_ff.step == GAIN_LOW)
    else $error("upper threshold crossing did not select lowest gain");

  restore_wait_a: assert property (@(posedge core_clk) disable iff (srst) // see RULE_05
    filt_valid && trig_lo_ff && agc_en_ff && level_hys >= lo_thr |=> trig_lo_ff)
    else $error("gain restored inside hysteresis band");

  restore_go_a: assert property (@(posedge core_clk) disable iff (srst) // see RULE_05
    release_s |=> !trig_lo_ff)
    else $error("gain not restored below hysteresis");

  gain_map_a: assert property (@(posedge core_clk) disable iff (srst) // see RULE_11
    gain_out_ff.step == (trig_up_ff ? GAIN_LOW : (trig_lo_ff ? GAIN_MID : GAIN_MAX)))
    else $error("gain step disagrees with triggers");

  dgc_track_a: assert property (@(posedge core_clk) disable iff (srst) // see RULE_10
    ##1 $stable(dgc_mid_ff) && $stable(dgc_low_ff)
      |-> gain_out_ff.digital_gain_correction == dgc_of(gain_out_ff.step, dgc_mid_ff, dgc_low_ff))
    else $error("digital correction does not match gain step");

  hold_between_a: assert property (@(posedge core_clk) disable iff (srst) // see RULE_12
    !filt_valid |=> $stable(gain_out_ff.step))
    else $error("gain step changed without a filter sample");

  reset_gain_a: assert property (@(posedge core_clk) // see RULE_12
    srst |=> gain_out_ff.step == GAIN_MAX && !trig_lo_ff && !trig_up_ff)
    else $error("gain not maximum after reset");

  correct_path_a: assert property (@(posedge core_clk) disable iff (srst) // see RULE_08
    raw_in.valid |=> corr_valid_ff
      && corr_ff == correct_level($past(raw_in.level), $past(slope_ff), $past(offs_ff)))
    else $error("strength correction wrong");

  gain_latency_a: assert property (@(posedge core_clk) disable iff (srst) // see RULE_10
    raw_in.valid ##1 (!raw_in.valid)[*2] ##0 upper_cross_s |=> gain_out_ff.step == GAIN_LOW)
    else $error("sample to gain latency wrong");

endmodule

// [testbench/if_gain_model.sv]
`timescale 1ns/1ns
module if_gain_model (
  // Clock.
  input wire logic core_clk,
  // Sample request from the bench.
  input wire logic send,
  input wire logic [agc_pkg::RAW_W-1:0] power,
  // Strength samples to the block.
  output agc_pkg::raw_sample_type raw_in
);
  import agc_pkg::*;
  logic [RAW_W-1:0] last_ff = '0;
  initial raw_in = '0;
  // Between samples the level is inverted so a block that reads a stale level is caught.
  always @(posedge core_clk) begin
    if (send) begin
      raw_in <= {1'b1, power};
      last_ff <= power;
    end else begin
      raw_in <= {1'b0, ~last_ff};
    end
  end
endmodule

// [testbench/test_agc_threshold_decision.sv]
`timescale 1ns/1ns
`define check_eq(got, exp) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("wrong value at %0t ns: %h versus %h", $time, (got), (exp)); \
  end \
end
module test_agc_threshold_decision;
  import agc_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  raw_sample_type raw_in;
  gain_out_type gain_out;
  logic [STR_W-1:0] filt_level;
  logic send = 1'b0;
  logic [RAW_W-1:0] power = '0;
  int fails = 0;
  int checked = 0;
  int seed = 32'h442e;
  int sh[13];
  int wid[13] = '{10, 9, 9, 9, 12, 8, 4, 4, 8, 8, 1, 0, 0};
  int corner[10] = '{766, 767, 894, 895, 700, 681, 554, 553, 900, 600};
  int acc, y, lt, ut, st;

  always #50 core_clk = ~core_clk;

  agc_threshold_decision dut_u (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .raw_in(raw_in), .gain_out(gain_out), .filt_level(filt_level));
  if_gain_model model_u (.core_clk(core_clk), .send(send), .power(power), .raw_in(raw_in));

  function automatic void apply(input int lvl);
    int x;
    int df;
    int lo;
    int up;
    x = ((lvl * sh[5]) >>> 6) + ((sh[4] >= 2048) ? sh[4] - 4096 : sh[4]);
    x = (x < 0) ? 0 : (x > 4095) ? 4095 : x;
    df = (x << 8) - acc;
    acc = acc + ((df > 0) ? (df >>> sh[6]) : (df >>> (sh[6] + sh[7])));
    y = acc >>> 8;
    lo = sh[0] + sh[1];
    up = sh[0] + sh[2];
    lt = (sh[10] == 0 || y + sh[3] < lo) ? 0 : (y >= lo) ? 1 : lt;
    ut = (sh[10] == 0 || y + sh[3] < up) ? 0 : (y >= up) ? 1 : ut;
    st = ut ? 2 : lt;
  endfunction

  function automatic logic [DATA_W-1:0] exp_reg(input int i);
    if (i > 12) return '0;
    if (i == 11) return DATA_W'({ut[0], lt[0], st[1:0]});
    if (i == 12) return DATA_W'(y);
    return DATA_W'(sh[i]);
  endfunction

  function automatic gain_out_type exp_gain();
    gain_out_type g;
    g.step = gain_step_type'(st);
    g.digital_gain_correction = (st == 1) ? DGC_W'(sh[8]) : (st == 2) ? DGC_W'(sh[9]) : '0;
    return g;
  endfunction

  task automatic do_reset();
    srst <= 1'b1;
    repeat (7) @(posedge core_clk);
    #1;
    `check_eq(gain_out, gain_out_type'(0))
    @(posedge core_clk);
    srst <= 1'b0;
    sh = '{10'h27f, 9'h080, 9'h100, 9'h0d5, RST_STR_OFFS, RST_STR_SLOPE, RST_RISE,
      RST_FALL, RST_DGC_MID, RST_DGC_LOW, RST_AGC_EN, 0, 0};
    acc = 0;
    y = 0;
    lt = 0;
    ut = 0;
    st = 0;
  endtask

  task automatic wr(input int i, input int v);
    reg_addr <= ADDR_W'(i * 4);
    reg_wdata <= DATA_W'(v);
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // One idle edge keeps a following write from lowering and raising the strobe at once.
    @(posedge core_clk);
    if (i < 11) sh[i] = v & ((1 << wid[i]) - 1);
  endtask

  task automatic rd_chk(input int i);
    reg_addr <= ADDR_W'(i * 4);
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `check_eq(reg_rdata, exp_reg(i))
    @(posedge core_clk);
  endtask

  // The decision lands a fixed three edges after the sample is taken.
  task automatic settle();
    repeat (4) @(posedge core_clk);
    #1;
    `check_eq(gain_out, exp_gain())
    `check_eq(filt_level, STR_W'(y))
    @(posedge core_clk);
    rd_chk(11);
  endtask

  task automatic level(input int v);
    power <= RAW_W'(v);
    send <= 1'b1;
    @(posedge core_clk);
    apply(v);
    send <= 1'b0;
    settle();
  endtask

  task automatic burst(input int n);
    for (int k = 0; k < n; k++) begin
      power <= RAW_W'($random(seed));
      send <= 1'b1;
      @(posedge core_clk);
      apply(power);
    end
    send <= 1'b0;
    settle();
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #5000000;
    fails++;
    final_report();
  end

  initial begin
    do_reset();
    for (int i = 0; i < 16; i++) rd_chk(i);
    $display("test reset done");
    for (int i = 0; i < 16; i++) wr(i, 32'hffff);
    for (int i = 0; i < 16; i++) rd_chk(i);
    do_reset();
    for (int i = 0; i < 4; i++) rd_chk(i);
    $display("test access done");
    wr(0, 32'h27f);
    wr(6, 0);
    wr(7, 0);
    foreach (corner[k]) level(corner[k]);
    wr(8, 32'h42);
    @(posedge core_clk);
    #1;
    `check_eq(gain_out.digital_gain_correction, DGC_W'(8'h42))
    @(posedge core_clk);
    $display("test thresholds done");
    wr(10, 0);
    level(900);
    wr(10, 1);
    level(600);
    level(800);
    $display("test enable done");
    for (int k = 0; k < 2; k++) begin
      wr(0, k ? 32'h1ff : 32'h27f);
      wr(4, 32);
      wr(3, 213);
      wr(8, 155);
      burst(3);
    end
    $display("test common done");
    for (int n = 0; n < 30; n++) begin
      wr(0, $random(seed) & 32'h3ff);
      for (int i = 1; i < 10; i++) wr(i, $random(seed) & ((i == 6 || i == 7) ? 3 : 32'hfff));
      burst(1 + ($random(seed) & 3));
      rd_chk(12);
    end
    $display("test random done");
    final_report();
  end
endmodule
